// ### common/cfg_hdr_defs.svh
// constants for the selftest/header/latency word and the i/o base address word
`ifndef CFG_HDR_DEFS_SVH
`define CFG_HDR_DEFS_SVH

// configuration dword indices of the two words (byte address = 4 * index)
`define CFG_IDX_W 4
`define CFG_IDX_HDR 4'h3
`define CFG_IDX_IOBAR 4'h4

// reset values
`define HDR_RESET 32'h0000_0000
`define IOBAR_RESET 32'h0000_0001

// first word field positions
`define HDR_SELFTEST_CAPABLE_BIT 31
`define HDR_SELFTEST_START_BIT 30
`define HDR_RESULT_CODE_LSB 24
`define HDR_MULTIFUNCTION_BIT 23
`define HDR_LAYOUT_LSB 16
`define HDR_OCCUPANCY_LSB 8
`define HDR_LINE_SIZE_LSB 0

// fixed values of the constant fields
`define SELFTEST_RESULT_PASS 4'h0
`define LAYOUT_TYPE0 7'h00
`define LINE_SIZE_FIXED 8'h00

// i/o base word layout
`define IOBAR_BASE_LSB 8
`define IOBAR_BASE_W 24
`define IOBAR_SPACE_IO 1'b1
`define IOBAR_RSVD_BIT 1

// writable bit masks
`define HDR_WMASK 32'h0000_FF00
`define IOBAR_WMASK_BASE 32'h7FF0_0000
`define IOBAR_WMASK_EXT 32'hFFFF_FF00

// address bits compared during i/o decode
`define IO_CMP_MASK_BASE 32'hFFF0_0000
`define IO_CMP_MASK_EXT 32'hFFFF_FF00

`endif

// ### common/cfg_hdr_pkg.sv
// types for the configuration header word bank
package cfg_hdr_pkg;

  // complete state of the bank, registered as one word
  typedef struct packed {
    logic [7:0] bus_occupancy_timer;
    logic [23:0] io_window_base;
    logic pci_rd_valid;
    logic [31:0] pci_rd_data;
    logic lb_rd_valid;
    logic [31:0] lb_rd_data;
    logic io_claim;
    logic occupancy_active;
    logic [7:0] occupancy_count;
    logic occupancy_expired;
  } bank_state_t;

endpackage

// ### hdl/cfg_hdr_regs.sv
// configuration header words: selftest/header/latency word and i/o base address word
`timescale 1ns/100ps
`include "cfg_hdr_defs.svh"

module cfg_hdr_regs
  import cfg_hdr_pkg::*;
#(
  parameter bit EXTENDED = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sw_reset,
  // pci configuration access port
  input wire logic pci_cfg_rd,
  input wire logic pci_cfg_wr,
  input wire logic [`CFG_IDX_W-1:0] pci_cfg_idx,
  input wire logic [3:0] pci_cfg_be,
  input wire logic [31:0] pci_cfg_wdata,
  output logic pci_cfg_rvalid,
  output logic [31:0] pci_cfg_rdata,
  // local peripheral bus access port
  input wire logic lb_rd,
  input wire logic lb_wr,
  input wire logic [`CFG_IDX_W-1:0] lb_idx,
  input wire logic [3:0] lb_be,
  input wire logic [31:0] lb_wdata,
  output logic lb_rvalid,
  output logic [31:0] lb_rdata,
  // i/o decode of pci transfers
  input wire logic io_cmd_valid,
  input wire logic [31:0] io_cmd_addr,
  input wire logic io_space_enable,
  output logic io_claim,
  // bus master occupancy timing
  input wire logic master_owns_bus,
  output logic [7:0] bus_occupancy_timer,
  output logic occupancy_expired
);

  localparam logic [31:0] IOBAR_WMASK = EXTENDED ? `IOBAR_WMASK_EXT : `IOBAR_WMASK_BASE;
  localparam logic [31:0] IO_CMP_MASK = EXTENDED ? `IO_CMP_MASK_EXT : `IO_CMP_MASK_BASE;

  bank_state_t st;
  bank_state_t next_st;

  // view of the first word; every bit except the occupancy timer is a constant
  function automatic logic [31:0] hdr_word(input logic [7:0] occ);
    logic [31:0] w;
    w = `HDR_RESET;
    w[`HDR_SELFTEST_CAPABLE_BIT] = 1'b0;
    w[`HDR_SELFTEST_START_BIT] = 1'b0;
    w[`HDR_RESULT_CODE_LSB +: 4] = `SELFTEST_RESULT_PASS;
    w[`HDR_MULTIFUNCTION_BIT] = 1'b0;
    w[`HDR_LAYOUT_LSB +: 7] = `LAYOUT_TYPE0;
    w[`HDR_LINE_SIZE_LSB +: 8] = `LINE_SIZE_FIXED;
    w[`HDR_OCCUPANCY_LSB +: 8] = occ;
    return w;
  endfunction

  // view of the i/o base word; low byte is hardwired
  function automatic logic [31:0] iobar_word(input logic [23:0] base);
    logic [31:0] w;
    w = {base, 8'h00} & IOBAR_WMASK;
    w[`IOBAR_RSVD_BIT] = 1'b0;
    w[0] = `IOBAR_SPACE_IO;
    return w;
  endfunction

  // readback mux; unmapped indices read zero
  function automatic logic [31:0] read_word(input logic [`CFG_IDX_W-1:0] idx,
                                            input logic [7:0] occ, input logic [23:0] base);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (idx == `CFG_IDX_HDR) begin
      w = hdr_word(occ);
    end else if (idx == `CFG_IDX_IOBAR) begin
      w = iobar_word(base);
    end
    return w;
  endfunction

  // byte-enabled write merge restricted to the writable mask
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    return (old & ~m) | (wd & m);
  endfunction

  always_comb begin
    logic [31:0] cur_hdr;
    logic [31:0] cur_iobar;
    logic [31:0] new_hdr;
    logic [31:0] new_iobar;
    cur_hdr = hdr_word(st.bus_occupancy_timer);
    cur_iobar = iobar_word(st.io_window_base);
    new_hdr = cur_hdr;
    new_iobar = cur_iobar;
    next_st = st;

    // local bus writes first so that a same-cycle pci write to the same word wins
    if (lb_wr && lb_idx == `CFG_IDX_HDR) begin
      new_hdr = merge(new_hdr, lb_wdata, lb_be, `HDR_WMASK);
    end
    if (lb_wr && lb_idx == `CFG_IDX_IOBAR) begin
      new_iobar = merge(new_iobar, lb_wdata, lb_be, IOBAR_WMASK);
    end
    if (pci_cfg_wr && pci_cfg_idx == `CFG_IDX_HDR) begin
      new_hdr = merge(new_hdr, pci_cfg_wdata, pci_cfg_be, `HDR_WMASK);
    end
    if (pci_cfg_wr && pci_cfg_idx == `CFG_IDX_IOBAR) begin
      new_iobar = merge(new_iobar, pci_cfg_wdata, pci_cfg_be, IOBAR_WMASK);
    end
    next_st.bus_occupancy_timer = new_hdr[`HDR_OCCUPANCY_LSB +: 8];
    next_st.io_window_base = new_iobar[`IOBAR_BASE_LSB +: `IOBAR_BASE_W] & IOBAR_WMASK[31:8];

    // read data is sampled from the word as it stood before this cycle's writes
    next_st.pci_rd_valid = pci_cfg_rd;
    next_st.pci_rd_data = pci_cfg_rd ? read_word(pci_cfg_idx, st.bus_occupancy_timer, st.io_window_base)
                                     : 32'h0000_0000;
    next_st.lb_rd_valid = lb_rd;
    next_st.lb_rd_data = lb_rd ? read_word(lb_idx, st.bus_occupancy_timer, st.io_window_base)
                               : 32'h0000_0000;

    // i/o decode: only the window's high bits take part; an unprogrammed base
    // still decodes at zero, so software must set it before use
    next_st.io_claim = io_cmd_valid && io_space_enable &&
                       ((io_cmd_addr & IO_CMP_MASK) == (cur_iobar & IO_CMP_MASK));

    // occupancy timer: loaded when mastership begins, counts down while held
    next_st.occupancy_active = master_owns_bus;
    if (master_owns_bus && !st.occupancy_active) begin
      next_st.occupancy_count = st.bus_occupancy_timer;
      next_st.occupancy_expired = (st.bus_occupancy_timer == 8'h00);
    end else if (master_owns_bus) begin
      if (st.occupancy_count != 8'h00) begin
        next_st.occupancy_count = st.occupancy_count - 8'h01;
      end
      next_st.occupancy_expired = (st.occupancy_count <= 8'h01);
    end else begin
      next_st.occupancy_count = 8'h00;
      next_st.occupancy_expired = 1'b0;
    end
  end

  // one register bank; both resets bring the words to their documented values
  always_ff @(posedge clk_sys) begin
    if (!rst_n || sw_reset) begin
      st <= '0;
      // the shifted reset words are cut to their field widths on purpose
      st.bus_occupancy_timer <= 8'(`HDR_RESET >> `HDR_OCCUPANCY_LSB);
      st.io_window_base <= 24'(`IOBAR_RESET >> `IOBAR_BASE_LSB);
    end else begin
      st <= next_st;
    end
  end

  assign pci_cfg_rvalid = st.pci_rd_valid;
  assign pci_cfg_rdata = st.pci_rd_data;
  assign lb_rvalid = st.lb_rd_valid;
  assign lb_rdata = st.lb_rd_data;
  assign io_claim = st.io_claim;
  assign bus_occupancy_timer = st.bus_occupancy_timer;
  assign occupancy_expired = st.occupancy_expired;

endmodule

// ### tb/cfg_hdr_regs_sva.sv
// assertions on the ports of the configuration header words
`timescale 1ns/100ps
module cfg_hdr_regs_sva #(
  parameter bit EXTENDED = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sw_reset,
  input wire logic pci_cfg_rd,
  input wire logic pci_cfg_wr,
  input wire logic [3:0] pci_cfg_idx,
  input wire logic pci_cfg_rvalid,
  input wire logic [31:0] pci_cfg_rdata,
  input wire logic lb_rd,
  input wire logic lb_wr,
  input wire logic [3:0] lb_idx,
  input wire logic [31:0] lb_rdata,
  input wire logic io_cmd_valid,
  input wire logic io_space_enable,
  input wire logic io_claim,
  input wire logic master_owns_bus,
  input wire logic [7:0] bus_occupancy_timer,
  input wire logic occupancy_expired
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // a taken read and its answer one cycle later
  sequence s_rd(logic [3:0] i);
    pci_cfg_rd && !sw_reset && pci_cfg_idx == i ##1 pci_cfg_rvalid;
  endsequence
  a_read_answers: assert property (pci_cfg_rd && !sw_reset |=> pci_cfg_rvalid)
    else $error("read not answered");
  a_hdr_fixed: assert property (s_rd(4'h3) |-> (pci_cfg_rdata & 32'hFFFF_00FF) == 32'h0)
    else $error("header word fixed bit set");
  a_bar_low: assert property (s_rd(4'h4) |-> pci_cfg_rdata[7:0] == 8'h01)
    else $error("io base low bits wrong");
  a_bar_base: assert property (s_rd(4'h4) |-> EXTENDED || pci_cfg_rdata[31:20] == {1'b0, pci_cfg_rdata[30:20]}
    && pci_cfg_rdata[19:8] == 12'h000)
    else $error("io base fixed bits set");
  a_lb_fixed: assert property (lb_rd && !sw_reset && lb_idx == 4'h3 |=> (lb_rdata & 32'hFFFF_00FF) == 32'h0)
    else $error("local header word fixed bit set");
  a_timer_copy: assert property (pci_cfg_rd && pci_cfg_idx == 4'h3 && !pci_cfg_wr && !lb_wr && !sw_reset
    |=> pci_cfg_rdata[15:8] == bus_occupancy_timer)
    else $error("timer output differs from field");
  a_reset_clears: assert property (sw_reset |=> !pci_cfg_rvalid && !io_claim && bus_occupancy_timer == 8'h00)
    else $error("software reset left state");
  a_claim_cause: assert property (io_claim |-> $past(io_cmd_valid && io_space_enable))
    else $error("claim without enabled command");
  a_expiry_drops: assert property (!master_owns_bus ##1 !master_owns_bus |-> !occupancy_expired)
    else $error("expiry held after mastership");
endmodule
bind cfg_hdr_regs cfg_hdr_regs_sva #(.EXTENDED(EXTENDED)) u_cfg_hdr_regs_sva (.*);

// ### tb/pci_cfg_master.sv
// configuration master model on the pci side of the header words
`timescale 1ns/100ps
module pci_cfg_master (
  input wire logic clk_sys,
  output logic pci_cfg_rd = 1'b0,
  output logic pci_cfg_wr = 1'b0,
  output logic [3:0] pci_cfg_idx = 4'h0,
  output logic [3:0] pci_cfg_be = 4'hF,
  output logic [31:0] pci_cfg_wdata = 32'h0,
  input wire logic pci_cfg_rvalid,
  input wire logic [31:0] pci_cfg_rdata
);
  // write: one taken edge, then stale data is scrambled so it cannot be reused
  task automatic put(input logic [3:0] i, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk_sys) pci_cfg_wr <= 1'b1;
    pci_cfg_idx <= i;
    pci_cfg_be <= b;
    pci_cfg_wdata <= (i == 4'h4) ? (d & 32'hFFFF_FFFD) : d; // reserved bit kept zero
    @(posedge clk_sys) pci_cfg_wr <= 1'b0;
    pci_cfg_wdata <= ~pci_cfg_wdata;
  endtask
  // read: answer taken one cycle after the request edge
  task automatic get(input logic [3:0] i, output logic [31:0] d);
    @(posedge clk_sys) pci_cfg_rd <= 1'b1;
    pci_cfg_idx <= i;
    @(posedge clk_sys) pci_cfg_rd <= 1'b0;
    #1 d = pci_cfg_rvalid ? pci_cfg_rdata : 32'hDEAD_BEEF;
  endtask
endmodule

// ### tb/cfg_hdr_regs_tb.sv
// self-checking bench for the configuration header words
`timescale 1ns/100ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin err_total++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module cfg_hdr_regs_tb;
  logic clk_sys = 1'b0, rst_n = 1'b0, sw_reset = 1'b0, lb_rd = 1'b0, lb_wr = 1'b0;
  logic io_cmd_valid = 1'b0, io_space_enable = 1'b0, master_owns_bus = 1'b0;
  logic [3:0] lb_idx = 4'h0, lb_be = 4'hF;
  logic [31:0] lb_wdata = 32'h0, io_cmd_addr = 32'h0, q;
  wire logic pci_cfg_rd, pci_cfg_wr, pci_cfg_rvalid, lb_rvalid, io_claim, occupancy_expired;
  wire logic [3:0] pci_cfg_idx, pci_cfg_be;
  wire logic [31:0] pci_cfg_wdata, pci_cfg_rdata, lb_rdata;
  wire logic [7:0] bus_occupancy_timer;
  int err_total = 0, total_checks = 0, n;
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  cfg_hdr_regs u_cfg_hdr_regs (.*);
  pci_cfg_master u_pci_cfg_master (.*);
  task automatic lput(input logic [3:0] i, input logic [31:0] d);
    @(posedge clk_sys) lb_wr <= 1'b1;
    lb_idx <= i;
    lb_wdata <= d;
    @(posedge clk_sys) lb_wr <= 1'b0;
  endtask
  task automatic lget(input logic [3:0] i, output logic [31:0] d);
    @(posedge clk_sys) lb_rd <= 1'b1;
    lb_idx <= i;
    @(posedge clk_sys) lb_rd <= 1'b0;
    #1 d = lb_rvalid ? lb_rdata : 32'hDEAD_BEEF;
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // main sequence: reset values, write masks, decode, occupancy, software reset
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    u_pci_cfg_master.get(4'h3, q);
    `CHK("hdr reset", 32'h0000_0000, q)
    u_pci_cfg_master.get(4'h4, q);
    `CHK("bar reset", 32'h0000_0001, q)
    u_pci_cfg_master.put(4'h3, 32'hFFFF_FFFF, 4'hF);
    lget(4'h3, q);
    `CHK("hdr ones", 32'h0000_FF00, q)
    `CHK("timer", 8'hFF, bus_occupancy_timer)
    u_pci_cfg_master.put(4'h3, 32'h0000_0200, 4'hD);
    lget(4'h3, q);
    `CHK("hdr lanes", 32'h0000_FF00, q)
    u_pci_cfg_master.put(4'h3, 32'h0000_0200, 4'h2);
    // base is programmed before any i/o traffic
    lput(4'h4, 32'hFFFF_FFFD);
    u_pci_cfg_master.get(4'h4, q);
    `CHK("bar ones", 32'h7FF0_0001, q)
    for (n = 0; n < 3; n++) begin
      @(posedge clk_sys) io_cmd_valid <= 1'b1;
      io_space_enable <= (n != 2);
      io_cmd_addr <= (n == 1) ? 32'h0010_0000 : 32'h7FF0_0ABC;
      @(posedge clk_sys) io_cmd_valid <= 1'b0;
      #1 `CHK("claim", (n == 0), io_claim)
    end
    @(posedge clk_sys) master_owns_bus <= 1'b1;
    for (n = 0; n < 20 && occupancy_expired !== 1'b1; n++) @(posedge clk_sys) #1;
    `CHK("expiry cycles", 3, n)
    @(posedge clk_sys) master_owns_bus <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 `CHK("expiry off", 1'b0, occupancy_expired)
    @(posedge clk_sys) sw_reset <= 1'b1;
    @(posedge clk_sys) sw_reset <= 1'b0;
    lget(4'h4, q);
    `CHK("bar soft", 32'h0000_0001, q)
    lget(4'h3, q);
    `CHK("hdr soft", 32'h0000_0000, q)
    lget(4'h5, q);
    `CHK("unmapped", 32'h0000_0000, q)
    summarize();
  end
endmodule
